// [udbp_pkg.sv]
// Shared constants for the serial data buffer port
package udbp_pkg;
  // Data buffer address and reset value
  localparam logic [7:0] UDBP_DATA_ADDR = 8'h99;
  localparam logic [7:0] UDBP_DATA_RESET = 8'h00;
  // Bit positions inside a frame
  localparam logic [2:0] UDBP_LAST_DATA_BIT = 3'h7;
  // Reload timer rolls over at this count
  localparam logic [8:0] UDBP_TIMER_TOP = 9'h100;
  // Prescaler terminal counts (divide minus one)
  localparam logic [5:0] UDBP_DIV4_LAST = 6'h03;
  localparam logic [5:0] UDBP_DIV12_LAST = 6'h0B;
  localparam logic [5:0] UDBP_DIV48_LAST = 6'h2F;
  localparam logic [2:0] UDBP_EXT_DIV8_LAST = 3'h7;
  // Prescale select encodings
  localparam logic [1:0] UDBP_SEL_DIV12 = 2'h0;
  localparam logic [1:0] UDBP_SEL_DIV4 = 2'h1;
  localparam logic [1:0] UDBP_SEL_DIV48 = 2'h2;
  localparam logic [1:0] UDBP_SEL_EXT8 = 2'h3;
  // Transmit FIFO shape
  localparam int UDBP_FIFO_WIDTH = 8;
  localparam int UDBP_FIFO_DEPTH = 8;

  // Half a bit time in timer clocks: one reload-to-rollover run
  function automatic logic [8:0] udbp_half_bit(input logic [7:0] reload);
    return UDBP_TIMER_TOP - {1'b0, reload};
  endfunction : udbp_half_bit
endpackage : udbp_pkg

// [udbp_fifo.sv]
`timescale 1ns/1ps
// Small flop FIFO with valid/ready on both sides
module udbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : udbp_fifo

// [udbp_top.sv]
`timescale 1ns/1ps
module udbp_top
  import udbp_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_WRITE_READY,
  // Mode and control bits
  input wire logic MODE_NINE_BIT,
  input wire logic MULTIPROCESSOR_ENABLE,
  input wire logic RECEIVE_ENABLE_BIT,
  input wire logic NINTH_TRANSMIT_BIT,
  // Bit rate timer setup
  input wire logic TIMER_SYSCLK_SELECT,
  input wire logic [1:0] TIMER_PRESCALE_SELECT,
  input wire logic [7:0] TIMER_RELOAD,
  input wire logic EXTERNAL_CLOCK_INPUT,
  // Status flags
  input wire logic TRANSMIT_FLAG_CLEAR,
  input wire logic RECEIVE_FLAG_CLEAR,
  output logic TRANSMIT_COMPLETE_FLAG,
  output logic RECEIVE_COMPLETE_FLAG,
  output logic NINTH_RECEIVE_BIT,
  // Serial line
  output logic TX_LINE,
  input wire logic RX_LINE
);
  typedef enum logic [2:0] {
    UDBP_IDLE, UDBP_START, UDBP_DATA, UDBP_NINTH, UDBP_STOP
  } udbp_state_t;

  udbp_state_t tx_state;
  udbp_state_t rx_state;
  logic [5:0] pre_cnt;
  logic [2:0] ext_cnt;
  logic ext_prev;
  logic tclk;
  logic [5:0] pre_last;
  logic ext_tick;
  logic [8:0] half;
  logic [9:0] full_m1;
  logic [9:0] tx_cnt;
  logic [9:0] rx_cnt;
  logic tx_end;
  logic rx_end;
  logic [7:0] tx_shift;
  logic tx_ninth;
  logic [2:0] tx_idx;
  logic [7:0] rx_shift;
  logic rx_ninth;
  logic [2:0] rx_idx;
  logic rx_prev;
  logic [7:0] rx_latch;
  logic tx_flag;
  logic rx_flag;
  logic wr_hit;
  logic rd_hit;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic ninth_val;
  logic rx_load;
  logic tx_flag_set;

  // Only the data buffer address is mapped in this block
  function automatic logic udbp_is_data(input logic [7:0] a);
    return a == UDBP_DATA_ADDR;
  endfunction : udbp_is_data

  // Address decode for the shared data buffer
  assign wr_hit = SFR_WR && udbp_is_data(SFR_ADDR);
  assign rd_hit = SFR_RD && udbp_is_data(SFR_ADDR);

  // Writes go to the transmit path only; reads see only the latch
  udbp_fifo #(
    .WIDTH(UDBP_FIFO_WIDTH),
    .DEPTH(UDBP_FIFO_DEPTH)
  ) tx_fifo (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(wr_hit),
    .in_ready(SFR_WRITE_READY),
    .in_data(SFR_WDATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Timer clock: sysclk, a prescaled sysclk, or external edges over 8
  assign pre_last = (TIMER_PRESCALE_SELECT == UDBP_SEL_DIV12) ? UDBP_DIV12_LAST
                  : (TIMER_PRESCALE_SELECT == UDBP_SEL_DIV4) ? UDBP_DIV4_LAST
                  : UDBP_DIV48_LAST;
  assign ext_tick = EXTERNAL_CLOCK_INPUT && !ext_prev
                    && (ext_cnt == UDBP_EXT_DIV8_LAST);
  assign tclk = TIMER_SYSCLK_SELECT ? 1'b1
              : (TIMER_PRESCALE_SELECT == UDBP_SEL_EXT8) ? ext_tick
              : (pre_cnt >= pre_last);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pre_cnt <= '0;
      ext_cnt <= '0;
      ext_prev <= 1'b0;
    end else begin
      pre_cnt <= (pre_cnt >= pre_last) ? '0 : pre_cnt + 6'h01;
      ext_prev <= EXTERNAL_CLOCK_INPUT;
      if (EXTERNAL_CLOCK_INPUT && !ext_prev) begin
        ext_cnt <= ext_cnt + 3'h1;
      end
    end
  end

  // Bit time is two reload runs; half a bit finds the start-bit middle
  assign half = udbp_half_bit(TIMER_RELOAD);
  assign full_m1 = {half, 1'b0} - 10'h001;
  assign tx_end = tclk && (tx_cnt == '0);
  assign rx_end = tclk && (rx_cnt == '0);

  // Transmitter takes the next byte only when idle
  assign f_ready = (tx_state == UDBP_IDLE);
  assign tx_flag_set = tx_end && (tx_state == UDBP_NINTH
                    || (tx_state == UDBP_DATA && tx_idx == UDBP_LAST_DATA_BIT
                        && !MODE_NINE_BIT));

  // Transmit frame sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_state <= UDBP_IDLE;
      tx_shift <= UDBP_DATA_RESET;
      tx_ninth <= 1'b0;
      tx_idx <= '0;
      tx_cnt <= '0;
      TX_LINE <= 1'b1;
    end else begin
      tx_cnt <= (tx_state == UDBP_IDLE || tx_end) ? full_m1
              : tclk ? tx_cnt - 10'h001 : tx_cnt;
      case (tx_state)
        UDBP_IDLE: if (f_valid) begin
          tx_shift <= f_data;
          tx_ninth <= NINTH_TRANSMIT_BIT;
          tx_idx <= '0;
          TX_LINE <= 1'b0;
          tx_state <= UDBP_START;
        end
        UDBP_START: if (tx_end) begin
          TX_LINE <= tx_shift[0];
          tx_state <= UDBP_DATA;
        end
        UDBP_DATA: if (tx_end) begin
          if (tx_idx == UDBP_LAST_DATA_BIT) begin
            TX_LINE <= MODE_NINE_BIT ? tx_ninth : 1'b1;
            tx_state <= MODE_NINE_BIT ? UDBP_NINTH : UDBP_STOP;
          end else begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            TX_LINE <= tx_shift[1];
            tx_idx <= tx_idx + 3'h1;
          end
        end
        UDBP_NINTH: if (tx_end) begin
          TX_LINE <= 1'b1;
          tx_state <= UDBP_STOP;
        end
        default: if (tx_end) begin
          tx_state <= UDBP_IDLE;
        end
      endcase
    end
  end

  // With MULTIPROCESSOR_ENABLE the stop-time sample gates the load in 8-bit mode; in 9-bit mode the ninth bit does and stop is ignored
  assign ninth_val = MODE_NINE_BIT ? rx_ninth : RX_LINE;
  assign rx_load = (rx_state == UDBP_STOP) && rx_end && !rx_flag
                   && (!MULTIPROCESSOR_ENABLE || ninth_val);

  // Receive frame sequencer; a start bit that is gone at mid-bit is noise
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_state <= UDBP_IDLE;
      rx_shift <= UDBP_DATA_RESET;
      rx_ninth <= 1'b0;
      rx_idx <= '0;
      rx_cnt <= '0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= RX_LINE;
      rx_cnt <= (rx_state == UDBP_IDLE) ? {1'b0, half} - 10'h001
              : rx_end ? full_m1 : tclk ? rx_cnt - 10'h001 : rx_cnt;
      case (rx_state)
        UDBP_IDLE: if (RECEIVE_ENABLE_BIT && rx_prev && !RX_LINE) begin
          rx_idx <= '0;
          rx_state <= UDBP_START;
        end
        UDBP_START: if (rx_end) begin
          rx_state <= RX_LINE ? UDBP_IDLE : UDBP_DATA;
        end
        UDBP_DATA: if (rx_end) begin
          rx_shift <= {RX_LINE, rx_shift[7:1]};
          rx_idx <= rx_idx + 3'h1;
          if (rx_idx == UDBP_LAST_DATA_BIT) begin
            rx_state <= MODE_NINE_BIT ? UDBP_NINTH : UDBP_STOP;
          end
        end
        UDBP_NINTH: if (rx_end) begin
          rx_ninth <= RX_LINE;
          rx_state <= UDBP_STOP;
        end
        default: if (rx_end) begin
          rx_state <= UDBP_IDLE;
        end
      endcase
    end
  end

  // Receive latch, flags and read data; a set beats a same-cycle clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_latch <= UDBP_DATA_RESET;
      NINTH_RECEIVE_BIT <= 1'b0;
      tx_flag <= 1'b0;
      rx_flag <= 1'b0;
      SFR_RDATA <= UDBP_DATA_RESET;
    end else begin
      if (rx_load) begin
        rx_latch <= rx_shift;
        NINTH_RECEIVE_BIT <= ninth_val;
      end
      rx_flag <= rx_load || (rx_flag && !RECEIVE_FLAG_CLEAR);
      tx_flag <= tx_flag_set || (tx_flag && !TRANSMIT_FLAG_CLEAR);
      if (rd_hit) begin
        SFR_RDATA <= rx_latch;
      end
    end
  end

  assign TRANSMIT_COMPLETE_FLAG = tx_flag;
  assign RECEIVE_COMPLETE_FLAG = rx_flag;

  // Checks on the documented behaviour
  default clocking udbp_cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence udbp_enter_stop_s;
    (tx_state != UDBP_STOP) ##1 (tx_state == UDBP_STOP);
  endsequence

  sequence udbp_take_byte_s;
    (tx_state == UDBP_IDLE) && f_valid;
  endsequence

  write_keeps_latch_a: assert property ((wr_hit && !rx_load) |=>
    rx_latch == $past(rx_latch)) else $error("write changed rx latch");
  read_returns_latch_a: assert property (rd_hit |=>
    SFR_RDATA == $past(rx_latch)) else $error("read not from rx latch");
  write_queued_a: assert property ((wr_hit && SFR_WRITE_READY) |=>
    f_valid) else $error("written byte not queued");
  write_starts_frame_a: assert property (udbp_take_byte_s |=>
    (tx_state == UDBP_START) && !TX_LINE) else $error("no start bit");
  tx_bit_shift_a: assert property ((tx_state == UDBP_DATA) |->
    TX_LINE == tx_shift[0]) else $error("tx data bit wrong");
  ninth_flag_time_a: assert property ((MODE_NINE_BIT &&
    $stable(MODE_NINE_BIT)) ##0 udbp_enter_stop_s |-> tx_flag)
    else $error("tx flag late in 9-bit mode");
  rx_load_gate_a: assert property (rx_load |-> !rx_flag &&
    (!MULTIPROCESSOR_ENABLE || ninth_val) ##1 rx_flag
    && rx_latch == $past(rx_shift)) else $error("bad receive load");
  rx_ninth_store_a: assert property ((rx_load && MODE_NINE_BIT) |=>
    NINTH_RECEIVE_BIT == $past(rx_ninth)) else $error("ninth bit lost");
  flags_sticky_a: assert property ((rx_flag && !RECEIVE_FLAG_CLEAR)
    |=> rx_flag) else $error("rx flag dropped by hardware");
  bit_time_a: assert property ((tx_end && tx_state != UDBP_IDLE) |=>
    tx_cnt == {1'b0, ~$past(TIMER_RELOAD), 1'b1})
    else $error("bit time reload wrong");
endmodule : udbp_top

// [udbp_remote.sv]
`timescale 1ns/1ps
// Remote serial station: sends frames on demand, records what it hears
module udbp_remote #(
  parameter int BIT = 8
) (
  // Clock and mode
  input wire logic clk,
  input wire logic nine,
  // Line from the port, and its flag for timing checks
  input wire logic tx_in,
  input wire logic tx_flag,
  // Line into the port
  output logic rx_out
);
  // Per frame: bits after start, and the flag seen at each sample
  logic [9:0] got[$];
  logic [9:0] fl[$];
  logic [9:0] w;
  logic [9:0] f;
  int n;

  // Listener samples mid-bit; start edge gives the reference
  initial begin
    rx_out = 1'b1;
    forever begin
      @(negedge tx_in);
      repeat (BIT / 2) @(posedge clk);
      w = '0;
      f = '0;
      n = nine ? 10 : 9;
      for (int i = 0; i < n; i++) begin
        repeat (BIT) @(posedge clk);
        w[i] = tx_in;
        f[i] = tx_flag;
      end
      got.push_back(w);
      fl.push_back(f);
    end
  end

  // Sender: LSB first, stop always high, line idles high after
  task automatic send(input logic [7:0] d, input logic b9);
    logic [10:0] fr;
    fr = {1'b1, nine ? b9 : 1'b1, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(negedge clk);
      rx_out = fr[i];
      repeat (BIT - 1) @(negedge clk);
    end
  endtask : send
endmodule : udbp_remote

// [tb.sv]
`timescale 1ns/1ps
// Bench for the serial data buffer port
module tb;
  import udbp_pkg::*;
  // Reload FC gives a bit of 8 clocks, keeping frames short
  localparam int BIT = 8;
  logic clk, rst, wr, rd, ready, nine, mpe, ren, tb9;
  logic tflag, rflag, tclr, rclr, ninth_rx, txl, rxl, tsel;
  logic [1:0] tpre;
  logic [7:0] trel;
  logic [7:0] addr, wdata, rdata;
  int error_cnt, n_checks;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

  udbp_top uut (.CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .SFR_WRITE_READY(ready), .MODE_NINE_BIT(nine),
    .MULTIPROCESSOR_ENABLE(mpe), .RECEIVE_ENABLE_BIT(ren),
    .NINTH_TRANSMIT_BIT(tb9), .TIMER_SYSCLK_SELECT(tsel),
    .TIMER_PRESCALE_SELECT(tpre), .TIMER_RELOAD(trel),
    .EXTERNAL_CLOCK_INPUT(1'b0), .TRANSMIT_FLAG_CLEAR(tclr),
    .RECEIVE_FLAG_CLEAR(rclr), .TRANSMIT_COMPLETE_FLAG(tflag),
    .RECEIVE_COMPLETE_FLAG(rflag), .NINTH_RECEIVE_BIT(ninth_rx),
    .TX_LINE(txl), .RX_LINE(rxl));
  udbp_remote #(.BIT(BIT)) peer (.clk(clk), .nine(nine), .tx_in(txl),
    .tx_flag(tflag), .rx_out(rxl));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Register strobes last one cycle, changed at the falling edge
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_byte

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    `CHK("rdata", e, rdata)
  endtask : rd_chk

  // Software side clears the flags; the port never does
  task automatic clr(input logic t);
    @(negedge clk);
    if (t) tclr = 1'b1;
    else rclr = 1'b1;
    @(negedge clk);
    tclr = 1'b0;
    rclr = 1'b0;
  endtask : clr

  // Bounded wait for the peer to hear n frames; running out is a mismatch
  task automatic wait_tx(input int n);
    for (int i = 0; i < 3000 && peer.got.size() < n; i++) @(negedge clk);
    `CHK("frames heard", 1'b1, peer.got.size() >= n)
  endtask : wait_tx

  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // Tests need a few thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    {addr, wdata, wr, rd, nine, mpe, tb9, tclr, rclr} = '0;
    ren = 1'b1;
    tsel = 1'b1;
    tpre = UDBP_SEL_DIV12;
    trel = 8'hFC;
    rst = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    `CHK("rdata", UDBP_DATA_RESET, rdata)
    `CHK("tx idle", 1'b1, txl)
    `CHK("tflag", 1'b0, tflag)
    // Single write goes straight out, flag at end of last data bit
    wr_byte(UDBP_DATA_ADDR, 8'hA5);
    wait_tx(1);
    `CHK("tx byte", 10'h1A5, peer.got[0])
    `CHK("flag mid", 1'b0, peer.fl[0][7])
    `CHK("flag stop", 1'b1, peer.fl[0][8])
    `CHK("tflag held", 1'b1, tflag)
    clr(1'b1);
    `CHK("tflag clr", 1'b0, tflag)
    // Write elsewhere must not start a frame
    wr_byte(8'h98, 8'h77);
    repeat (12 * BIT) @(negedge clk);
    `CHK("frames", 1, peer.got.size())
    // Back-to-back writes, one frame each
    wr_byte(UDBP_DATA_ADDR, 8'h3C);
    wr_byte(UDBP_DATA_ADDR, 8'hC3);
    wait_tx(3);
    `CHK("tx b2b0", 10'h13C, peer.got[1])
    `CHK("tx b2b1", 10'h1C3, peer.got[2])
    // Receive, then a write must not disturb the read value
    peer.send(8'h5A, 1'b1);
    repeat (4) @(negedge clk);
    `CHK("rflag", 1'b1, rflag)
    `CHK("stop bit", 1'b1, ninth_rx)
    rd_chk(8'h98, 8'h00);
    rd_chk(UDBP_DATA_ADDR, 8'h5A);
    wr_byte(UDBP_DATA_ADDR, 8'hFF);
    rd_chk(UDBP_DATA_ADDR, 8'h5A);
    // Flag still set: next frame is not loaded
    peer.send(8'h11, 1'b1);
    repeat (4) @(negedge clk);
    rd_chk(UDBP_DATA_ADDR, 8'h5A);
    clr(1'b0);
    `CHK("rflag clr", 1'b0, rflag)
    wait_tx(4);
    `CHK("tx ff", 10'h1FF, peer.got[3])
    // Nine-bit receive with address filtering
    nine = 1'b1;
    mpe = 1'b1;
    peer.send(8'h22, 1'b0);
    repeat (4) @(negedge clk);
    `CHK("rflag mpe", 1'b0, rflag)
    rd_chk(UDBP_DATA_ADDR, 8'h5A);
    peer.send(8'h33, 1'b1);
    repeat (4) @(negedge clk);
    rd_chk(UDBP_DATA_ADDR, 8'h33);
    `CHK("ninth 1", 1'b1, ninth_rx)
    clr(1'b0);
    mpe = 1'b0;
    peer.send(8'h44, 1'b0);
    repeat (4) @(negedge clk);
    rd_chk(UDBP_DATA_ADDR, 8'h44);
    `CHK("ninth 0", 1'b0, ninth_rx)
    clr(1'b0);
    // Receiver disabled: a frame on the line is not taken
    ren = 1'b0;
    peer.send(8'h55, 1'b1);
    repeat (4) @(negedge clk);
    `CHK("rflag ren", 1'b0, rflag)
    rd_chk(UDBP_DATA_ADDR, 8'h44);
    ren = 1'b1;
    // Nine-bit transmit: flag rises with the stop bit
    clr(1'b1);
    tb9 = 1'b1;
    wr_byte(UDBP_DATA_ADDR, 8'h96);
    wait_tx(5);
    `CHK("tx nine", 10'h396, peer.got[4])
    `CHK("flag ninth", 1'b0, peer.fl[4][8])
    `CHK("flag stop9", 1'b1, peer.fl[4][9])
    // Fill the queue until refused, then drain it all
    nine = 1'b0;
    for (int i = 0; i < 9; i++) wr_byte(UDBP_DATA_ADDR, 8'(8'h10 + i));
    `CHK("ready full", 1'b0, ready)
    wr_byte(UDBP_DATA_ADDR, 8'hEE);
    wait_tx(14);
    repeat (12 * BIT) @(negedge clk);
    `CHK("frames all", 14, peer.got.size())
    for (int i = 0; i < 9; i++) begin
      `CHK("tx fill", 10'h110 + i, peer.got[5 + i])
    end
    `CHK("ready", 1'b1, ready)
    // Prescaled timer: clock over 4 with reload FF still gives 8-clock bits
    tsel = 1'b0;
    tpre = UDBP_SEL_DIV4;
    trel = 8'hFF;
    wr_byte(UDBP_DATA_ADDR, 8'h69);
    wait_tx(15);
    `CHK("tx div4", 10'h169, peer.got[14])
    peer.send(8'h96, 1'b1);
    repeat (4) @(negedge clk);
    rd_chk(UDBP_DATA_ADDR, 8'h96);
    conclude();
  end
endmodule : tb
